/* shared/acc_ph_pkg.sv */
// Constants shared by the product-high accumulator slice and its helpers.
// Assumes one processor clock domain and a 16-bit accumulator datapath.
package acc_ph_pkg;

   // ****************************************************************
   // Datapath and register-port widths
   // ****************************************************************
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int OPC_W  = 5;

   // ****************************************************************
   // Operation codes handled by this slice
   // ****************************************************************
   localparam logic [OPC_W-1:0] OP_XOR       = 5'h08;
   localparam logic [OPC_W-1:0] OP_OR        = 5'h09;
   localparam logic [OPC_W-1:0] OP_AND       = 5'h0a;
   localparam logic [OPC_W-1:0] OP_SHR       = 5'h0b;
   localparam logic [OPC_W-1:0] OP_SUB_PH    = 5'h0c;
   localparam logic [OPC_W-1:0] OP_ADD_PH    = 5'h0d;
   localparam logic [OPC_W-1:0] OP_MOV_PH    = 5'h0e;
   localparam logic [OPC_W-1:0] OP_SIGN_FILL = 5'h0f;
   localparam logic [OPC_W-1:0] OP_CMP       = 5'h10;

   // Logic unit selections
   localparam logic [1:0] LU_XOR = 2'h0;
   localparam logic [1:0] LU_OR  = 2'h1;
   localparam logic [1:0] LU_AND = 2'h2;
   localparam logic [1:0] LU_SHR = 2'h3;

   // ****************************************************************
   // Register map, field positions and reset values
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_PH       = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_ACC_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_OFF_BASE = 8'h20;
   localparam int                SLOT_SPAN     = 16;

   localparam int CTRL_SXM_BIT = 0;
   localparam int ST_CARRY_BIT = 0;
   localparam int ST_ZERO_BIT  = 1;
   localparam int ST_SIGN_BIT  = 2;

   localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
   localparam logic [DATA_W-1:0] PH_RST   = 16'h0000;
   localparam logic [DATA_W-1:0] ACC_RST  = 16'h0000;
   localparam logic              FLAG_RST = 1'b0;

   // ****************************************************************
   // Operation kinds after decode
   // ****************************************************************
   typedef enum logic [2:0] {
      K_NONE, K_LOGIC, K_SHR, K_SUB, K_ADD, K_MOV, K_FILL, K_CMP
   } op_kind_e;

endpackage

/* hw/acc_adder.sv */
// Adder/subtractor for the accumulator slice.
// Assumes the caller chooses inversion and carry-in; purely combinational.
`timescale 1ns/1ps
module acc_adder #(
   parameter int W = 16
) (
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic         invert_b,
   input  wire logic         carry_in,
   output logic      [W-1:0] sum,
   output logic              carry_out
);

   logic [W-1:0] b_eff;
   logic [W:0]   total;

   // Subtract is add of the complement; carry out means no borrow
   always_comb begin
      b_eff     = invert_b ? ~b : b;
      total     = {1'b0, a} + {1'b0, b_eff} + {{W{1'b0}}, carry_in};
      sum       = total[W-1:0];
      carry_out = total[W];
   end

endmodule

/* hw/acc_logic_unit.sv */
// Bitwise logic and one-place right shift for the accumulator slice.
// Assumes operands settle in the same cycle; purely combinational.
`timescale 1ns/1ps
module acc_logic_unit
   import acc_ph_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic [1:0]   sel,
   input  wire logic         fill_bit,
   output logic      [W-1:0] result,
   output logic              shifted_out
);

   // Shift takes operand a only; b is ignored there
   always_comb begin
      shifted_out = a[0];
      case (sel)
         LU_XOR:  result = a ^ b;
         LU_OR:   result = a | b;
         LU_AND:  result = a & b;
         default: result = {fill_bit, a[W-1:1]};
      endcase
   end

endmodule

/* hw/acc_ph_slice.sv */
// Accumulator slice for class 3 codes 01000..10011, with its own
// accumulator pairs, product-high register, control and status flags.
// Assumes the decoder gives one op_valid pulse per word, same clock.
//
// Function
// [RULE1] Code 01000: XOR accumulator with offset, write chosen destination, set status.
// [RULE2] Code 01001: OR accumulator with offset, write chosen destination, set status.
// [RULE3] Code 01010: AND accumulator with offset, write chosen destination, set status.
// [RULE4] Code 01011: shift source right one, top bit zero or sign per mode.
// [RULE5] Code 01100: source minus product-high, write destination, set status.
// [RULE6] String subtract from product-high uses the previous carry flag.
// [RULE7] Code 01101: source plus product-high, write destination, set status.
// [RULE8] String add with product-high includes the current carry flag.
// [RULE9] Code 01110: copy product-high into chosen destination, set status.
// [RULE10] String transfer chains zero result with the current zero flag.
// [RULE11] Code 01111: sign flag copied into all 16 destination bits.
// [RULE12] String sign fill pre-increments the accumulator index before writing.
// [RULE13] Code 10000: compare by subtraction, order set by swap bit, status only.
// [RULE14] Compare leaves both accumulators unchanged.
// [RULE15] String product-high ops and sign fill run once, keep carry/zero chain.
// [RULE16] Swap bit picks single operand and reverses two-operand order.
// [RULE17] Destination bit writes accumulator when 0, offset when 1.
// [RULE18] Codes 10001..10011 change neither accumulators nor status.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module acc_ph_slice
   import acc_ph_pkg::*;
#(
   parameter int ACC_COUNT = 16
) (
   input  wire logic                         mclk,
   input  wire logic                         rst,
   input  wire logic                         op_valid,
   input  wire logic [OPC_W-1:0]             class3_op_field,
   input  wire logic                         swap_sel,
   input  wire logic                         dest_sel,
   input  wire logic                         string_mode,
   input  wire logic [$clog2(ACC_COUNT)-1:0] acc_pointer_index,
   input  wire logic [ADDR_W-1:0]            reg_addr,
   input  wire logic [DATA_W-1:0]            reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [DATA_W-1:0]            reg_rdata,
   output logic      [DATA_W-1:0]            result_word,
   output logic                              op_done,
   output logic                              carry_flag,
   output logic                              zero_flag,
   output logic                              sign_flag
);

   localparam int IDX_W = $clog2(ACC_COUNT);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // Index wraps by bit width, and each bank has SLOT_SPAN bus slots
   if (ACC_COUNT < 2 || ACC_COUNT > SLOT_SPAN || (ACC_COUNT & (ACC_COUNT - 1)) != 0) begin : g_bad
      $error("ACC_COUNT must be a power of two from 2 to 16");
   end

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [DATA_W-1:0] acc_r [ACC_COUNT];
   logic [DATA_W-1:0] off_r [ACC_COUNT];
   logic [DATA_W-1:0] product_high_reg_r;
   logic              sign_extend_mode_r;
   logic              carry_flag_r;
   logic              zero_flag_r;
   logic              sign_flag_r;
   logic [DATA_W-1:0] result_r;
   logic [IDX_W-1:0]  wr_idx_r;
   logic              done_r;
   logic [DATA_W-1:0] rdata_r;

   // ****************************************************************
   // Decode
   // ****************************************************************
   op_kind_e          kind;
   logic [DATA_W-1:0] src_acc;
   logic [DATA_W-1:0] src_off;
   logic [DATA_W-1:0] src_main;
   logic [DATA_W-1:0] src_other;
   logic [IDX_W-1:0]  wr_idx;
   logic              chain;

   // Codes outside this slice fall to K_NONE, as do the reserved ones
   always_comb begin
      kind = K_NONE;
      if (op_valid) begin
         case (class3_op_field)
            OP_XOR, OP_OR, OP_AND: kind = K_LOGIC;
            OP_SHR:                kind = K_SHR;
            OP_SUB_PH:             kind = K_SUB;
            OP_ADD_PH:             kind = K_ADD;
            OP_MOV_PH:             kind = K_MOV;
            OP_SIGN_FILL:          kind = K_FILL;
            OP_CMP:                kind = K_CMP;
            default:               kind = K_NONE; // RULE18
         endcase
      end
   end

   // Operand selection by the swap bit
   always_comb begin
      src_acc   = acc_r[acc_pointer_index];
      src_off   = off_r[acc_pointer_index];
      src_main  = swap_sel ? src_off : src_acc; // RULE16
      src_other = swap_sel ? src_acc : src_off; // RULE16
   end

   // String chaining: one word only, carry and zero carried over
   assign chain  = string_mode &&
                   (kind == K_SUB || kind == K_ADD || kind == K_MOV || kind == K_FILL); // RULE15
   // Sign fill in string mode writes the next accumulator address
   assign wr_idx = (kind == K_FILL && string_mode) ?
                   acc_pointer_index + IDX_W'(1) : acc_pointer_index; // RULE12

   // ****************************************************************
   // Arithmetic and logic units
   // ****************************************************************
   logic [DATA_W-1:0] add_b;
   logic              add_inv;
   logic              add_cin;
   logic [DATA_W-1:0] add_sum;
   logic              add_cout;
   logic [1:0]        lu_sel;
   logic [DATA_W-1:0] lu_res;
   logic              lu_out_bit;

   // Compare subtracts the other accumulator, the rest use product-high
   always_comb begin
      add_b   = (kind == K_CMP) ? src_other : product_high_reg_r; // RULE13
      add_inv = (kind == K_SUB) || (kind == K_CMP);
      if (string_mode && (kind == K_SUB || kind == K_ADD)) begin
         add_cin = carry_flag_r; // RULE6 RULE8
      end else begin
         add_cin = add_inv;
      end
   end

   acc_adder #(
      .W (DATA_W)
   ) u_adder (
      .a         (src_main),
      .b         (add_b),
      .invert_b  (add_inv),
      .carry_in  (add_cin),
      .sum       (add_sum),
      .carry_out (add_cout)
   );

   assign lu_sel = (kind == K_SHR) ? LU_SHR : class3_op_field[1:0];

   acc_logic_unit #(
      .W (DATA_W)
   ) u_logic (
      .a           (src_main),
      .b           (src_other),
      .sel         (lu_sel),
      .fill_bit    (sign_extend_mode_r & src_main[DATA_W-1]), // RULE4
      .result      (lu_res),
      .shifted_out (lu_out_bit)
   );

   // ****************************************************************
   // Result and status next values
   // ****************************************************************
   logic [DATA_W-1:0] res_nxt;
   logic              writes;
   logic              carry_nxt;
   logic              zero_nxt;

   always_comb begin
      res_nxt   = add_sum;
      writes    = 1'b0;
      carry_nxt = carry_flag_r;
      case (kind)
         K_LOGIC: begin
            res_nxt = lu_res; // RULE1 RULE2 RULE3
            writes  = 1'b1;
         end
         K_SHR: begin
            res_nxt   = lu_res; // RULE4
            writes    = 1'b1;
            carry_nxt = lu_out_bit;
         end
         K_SUB, K_ADD: begin
            writes    = 1'b1; // RULE5 RULE7
            carry_nxt = add_cout;
         end
         K_MOV: begin
            res_nxt = product_high_reg_r; // RULE9
            writes  = 1'b1;
         end
         K_FILL: begin
            res_nxt = {DATA_W{sign_flag_r}}; // RULE11
            writes  = 1'b1;
         end
         K_CMP: begin
            carry_nxt = add_cout; // RULE14
         end
         default: begin
            res_nxt = result_r;
         end
      endcase
      // Chained words stay zero only if every word so far was zero
      zero_nxt = (res_nxt == '0) && (!chain || zero_flag_r); // RULE10 RULE15
   end

   // ****************************************************************
   // Accumulator banks
   // ****************************************************************
   // An op that writes a bank wins over a bus write in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < ACC_COUNT; i++) begin
            acc_r[i] <= ACC_RST;
            off_r[i] <= ACC_RST;
         end
      end else if (writes) begin
         if (dest_sel) begin
            off_r[wr_idx] <= res_nxt; // RULE17
         end else begin
            acc_r[wr_idx] <= res_nxt; // RULE17
         end
      end else if (reg_wr) begin
         for (int i = 0; i < ACC_COUNT; i++) begin
            if (reg_addr == ADDR_ACC_BASE + ADDR_W'(i)) begin
               acc_r[i] <= reg_wdata;
            end else if (reg_addr == ADDR_OFF_BASE + ADDR_W'(i)) begin
               off_r[i] <= reg_wdata;
            end
         end
      end
   end

   // ****************************************************************
   // Status flags
   // ****************************************************************
   // Hardware update beats a software write to status in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         carry_flag_r <= FLAG_RST;
         zero_flag_r  <= FLAG_RST;
         sign_flag_r  <= FLAG_RST;
      end else if (kind != K_NONE) begin
         carry_flag_r <= carry_nxt;
         zero_flag_r  <= zero_nxt;
         sign_flag_r  <= res_nxt[DATA_W-1];
      end else if (reg_wr && reg_addr == ADDR_STATUS) begin
         carry_flag_r <= reg_wdata[ST_CARRY_BIT];
         zero_flag_r  <= reg_wdata[ST_ZERO_BIT];
         sign_flag_r  <= reg_wdata[ST_SIGN_BIT];
      end
   end

   // Compare result lands here too, so software can see the difference
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         result_r <= ACC_RST;
         wr_idx_r <= '0;
         done_r   <= 1'b0;
      end else begin
         done_r <= (kind != K_NONE);
         if (kind != K_NONE) begin
            result_r <= res_nxt;
            wr_idx_r <= wr_idx;
         end
      end
   end

   // ****************************************************************
   // Register port
   // ****************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sign_extend_mode_r <= CTRL_RST[CTRL_SXM_BIT];
         product_high_reg_r <= PH_RST;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_CTRL) begin
            sign_extend_mode_r <= reg_wdata[CTRL_SXM_BIT];
         end else if (reg_addr == ADDR_PH) begin
            product_high_reg_r <= reg_wdata;
         end
      end
   end

   // Read data stand for one cycle only; unmapped addresses read zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= '0;
         if (reg_rd) begin
            if (reg_addr == ADDR_CTRL) begin
               rdata_r[CTRL_SXM_BIT] <= sign_extend_mode_r;
            end else if (reg_addr == ADDR_STATUS) begin
               rdata_r[ST_CARRY_BIT] <= carry_flag_r;
               rdata_r[ST_ZERO_BIT]  <= zero_flag_r;
               rdata_r[ST_SIGN_BIT]  <= sign_flag_r;
            end else if (reg_addr == ADDR_PH) begin
               rdata_r <= product_high_reg_r;
            end else if (reg_addr >= ADDR_ACC_BASE &&
                         reg_addr < ADDR_ACC_BASE + ADDR_W'(ACC_COUNT)) begin
               rdata_r <= acc_r[reg_addr[IDX_W-1:0]];
            end else if (reg_addr >= ADDR_OFF_BASE &&
                         reg_addr < ADDR_OFF_BASE + ADDR_W'(ACC_COUNT)) begin
               rdata_r <= off_r[reg_addr[IDX_W-1:0]];
            end
         end
      end
   end

   assign reg_rdata   = rdata_r;
   assign result_word = result_r;
   assign op_done     = done_r;
   assign carry_flag  = carry_flag_r;
   assign zero_flag   = zero_flag_r;
   assign sign_flag   = sign_flag_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_issue(logic [OPC_W-1:0] code, logic strm);
      op_valid && class3_op_field == code && string_mode == strm;
   endsequence

   a_xor_result: assert property (s_issue(OP_XOR, 1'b0) |=> // RULE1
      result_r == $past(src_acc ^ src_off)) else $error("xor result wrong");
   a_or_result: assert property (s_issue(OP_OR, 1'b0) |=> // RULE2
      result_r == $past(src_acc | src_off)) else $error("or result wrong");
   a_and_result: assert property (s_issue(OP_AND, 1'b0) |=> // RULE3
      result_r == $past(src_acc & src_off)) else $error("and result wrong");
   a_shift_fill: assert property (s_issue(OP_SHR, 1'b0) |=> // RULE4
      result_r == {$past(sign_extend_mode_r & src_main[DATA_W-1]), $past(src_main[DATA_W-1:1])})
      else $error("right shift wrong");
   a_sub_plain: assert property (s_issue(OP_SUB_PH, 1'b0) |=> // RULE5
      result_r == $past(src_main - product_high_reg_r)) else $error("ph subtract wrong");
   a_sub_borrow: assert property (s_issue(OP_SUB_PH, 1'b1) ##0 !carry_flag_r |=> // RULE6
      result_r == $past(src_main - product_high_reg_r - 16'h0001)) else $error("borrow lost");
   a_add_carry: assert property (s_issue(OP_ADD_PH, 1'b1) |=> // RULE8
      result_r == $past(src_main + product_high_reg_r + {15'h0000, carry_flag_r}))
      else $error("carry not added");
   a_zero_chain: assert property (s_issue(OP_MOV_PH, 1'b1) ##0 !zero_flag_r |=> // RULE10
      !zero_flag_r && result_r == $past(product_high_reg_r)) else $error("zero chain broken");
   a_fill_next: assert property (s_issue(OP_SIGN_FILL, 1'b1) |=> // RULE12
      wr_idx_r == $past(acc_pointer_index) + IDX_W'(1) && result_r == {DATA_W{$past(sign_flag_r)}})
      else $error("sign fill index wrong");
   a_cmp_keeps: assert property (op_valid && class3_op_field == OP_CMP |=> // RULE14
      acc_r[$past(acc_pointer_index)] == $past(src_acc) &&
      off_r[$past(acc_pointer_index)] == $past(src_off)) else $error("compare wrote");
   a_dest_route: assert property (s_issue(OP_MOV_PH, 1'b0) ##0 dest_sel |=> // RULE17
      off_r[$past(acc_pointer_index)] == $past(product_high_reg_r)) else $error("bad destination");
   a_reserved_idle: assert property (op_valid && class3_op_field > OP_CMP && // RULE18
      class3_op_field < 5'h14 |=> $stable(carry_flag_r) && $stable(zero_flag_r) &&
      $stable(sign_flag_r) && !op_done) else $error("reserved code acted");

endmodule

/* testbench/op_seq_model.sv */
// Stand-in for the instruction decoder and string sequencer.
// Assumes the slice samples the op port on the rising edge of mclk.
`timescale 1ns/1ps
module op_seq_model
   import acc_ph_pkg::*;
(
   input  wire logic             mclk,
   output logic                  op_valid,
   output logic [OPC_W-1:0]      class3_op_field,
   output logic                  swap_sel,
   output logic                  dest_sel,
   output logic                  string_mode,
   output logic [3:0]            acc_pointer_index
);
   // Idle fields carry junk so the slice cannot lean on stale values
   initial begin
      op_valid = 1'b0;
      class3_op_field = 5'h1f;
      swap_sel = 1'b1;
      dest_sel = 1'b1;
      string_mode = 1'b1;
      acc_pointer_index = 4'hf;
   end

   // One word: launch after an edge, hold through the taking edge
   task automatic issue(input logic [4:0] c, input logic sw, ds, st,
                        input logic [3:0] ix);
      @(posedge mclk);
      op_valid <= 1'b1;
      class3_op_field <= c;
      swap_sel <= sw;
      dest_sel <= ds;
      string_mode <= st;
      acc_pointer_index <= ix;
      @(posedge mclk);
      op_valid <= 1'b0;
      class3_op_field <= ~c;
      swap_sel <= ~sw;
      dest_sel <= ~ds;
      string_mode <= ~st;
      acc_pointer_index <= ~ix;
   endtask
endmodule

/* testbench/test_acc_ph_slice.sv */
// Self-checking bench for the product-high accumulator slice.
// Assumes the slice's register map, flag packing and one-cycle op latency.
`timescale 1ns/1ps
module test_acc_ph_slice
   import acc_ph_pkg::*;
;
   logic        mclk, rst, op_valid, swap_sel, dest_sel, string_mode;
   logic [4:0]  class3_op_field;
   logic [3:0]  acc_pointer_index;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, result_word;
   logic        reg_wr, reg_rd, op_done, carry_flag, zero_flag, sign_flag;
   int          n_fail, samples_checked, cyc;

   acc_ph_slice u_acc_ph_slice (.mclk(mclk), .rst(rst), .op_valid(op_valid),
      .class3_op_field(class3_op_field), .swap_sel(swap_sel), .dest_sel(dest_sel),
      .string_mode(string_mode), .acc_pointer_index(acc_pointer_index),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .result_word(result_word), .op_done(op_done),
      .carry_flag(carry_flag), .zero_flag(zero_flag), .sign_flag(sign_flag));

   op_seq_model u_op_seq_model (.mclk(mclk), .op_valid(op_valid),
      .class3_op_field(class3_op_field), .swap_sel(swap_sel), .dest_sel(dest_sel),
      .string_mode(string_mode), .acc_pointer_index(acc_pointer_index));

   // ****************************************
   // Clock and hang guard
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Whole run is under a hundred cycles; the ceiling leaves wide margin
   initial begin
      cyc = 0;
      forever begin
         @(posedge mclk);
         cyc++;
         if (cyc > 3000) begin
            n_fail++;
            test_done();
         end
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic test_done();
      if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", reg_rdata, e);
   endtask

   // Flags packed as carry, zero, sign
   task automatic op(input logic [4:0] c, input logic sw, ds, st, dn,
                     input logic [15:0] e, input logic [2:0] f);
      u_op_seq_model.issue(c, sw, ds, st, 4'h3);
      #1 chk("op_done", {15'h0, op_done}, {15'h0, dn});
      chk("result_word", result_word, e);
      chk("flags", {13'h0, carry_flag, zero_flag, sign_flag}, {13'h0, f});
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      n_fail = 0;
      samples_checked = 0;
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      rd(8'h00, 16'h0000);
      rd(8'h01, 16'h0000);
      wr(8'h7f, 16'h1234);
      rd(8'h7f, 16'h0000);
      wr(8'h02, 16'h8001);
      wr(8'h13, 16'h0f0f);
      wr(8'h23, 16'h00ff);
      op(OP_XOR, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0ff0, 3'b000);
      rd(8'h23, 16'h0ff0);
      op(OP_OR, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0fff, 3'b000);
      op(OP_AND, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0ff0, 3'b000);
      rd(8'h13, 16'h0ff0);
      op(OP_MOV_PH, 1'b0, 1'b0, 1'b0, 1'b1, 16'h8001, 3'b001);
      // Sign fill of the shift first on, then off
      wr(8'h00, 16'h0001);
      op(OP_SHR, 1'b0, 1'b1, 1'b0, 1'b1, 16'hc000, 3'b101);
      wr(8'h00, 16'h0000);
      op(OP_SHR, 1'b1, 1'b1, 1'b0, 1'b1, 16'h6000, 3'b000);
      op(OP_ADD_PH, 1'b1, 1'b0, 1'b0, 1'b1, 16'he001, 3'b001);
      op(OP_SUB_PH, 1'b0, 1'b1, 1'b0, 1'b1, 16'h6000, 3'b100);
      op(OP_ADD_PH, 1'b1, 1'b0, 1'b1, 1'b1, 16'he002, 3'b001);
      op(OP_SUB_PH, 1'b0, 1'b1, 1'b1, 1'b1, 16'h6000, 3'b100);
      op(OP_CMP, 1'b0, 1'b0, 1'b0, 1'b1, 16'h8002, 3'b101);
      op(OP_CMP, 1'b1, 1'b1, 1'b0, 1'b1, 16'h7ffe, 3'b000);
      rd(8'h13, 16'he002);
      rd(8'h23, 16'h6000);
      // Zero chain: seeded set, then seeded clear, then plain
      wr(8'h02, 16'h0000);
      wr(8'h01, 16'h0002);
      op(OP_MOV_PH, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0000, 3'b010);
      wr(8'h01, 16'h0000);
      op(OP_MOV_PH, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0000, 3'b000);
      op(OP_MOV_PH, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, 3'b010);
      // Transfer into the offset bank, which still holds 6000
      op(OP_MOV_PH, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0000, 3'b010);
      rd(8'h23, 16'h0000);
      wr(8'h01, 16'h0004);
      op(OP_SIGN_FILL, 1'b0, 1'b0, 1'b0, 1'b1, 16'hffff, 3'b001);
      rd(8'h14, 16'h0000);
      op(OP_SIGN_FILL, 1'b0, 1'b0, 1'b1, 1'b1, 16'hffff, 3'b001);
      rd(8'h14, 16'hffff);
      // Reserved codes must leave result and flags alone
      for (int i = 17; i <= 19; i++) begin
         op(5'(i), 1'b0, 1'b0, 1'b0, 1'b0, 16'hffff, 3'b001);
      end
      rd(8'h13, 16'hffff);
      // Mid-run reset must clear result, flags and both filled slots
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      #1 chk("result_word", result_word, 16'h0000);
      chk("flags", {13'h0, carry_flag, zero_flag, sign_flag}, 16'h0000);
      rd(8'h13, 16'h0000);
      rd(8'h14, 16'h0000);
      test_done();
   end
endmodule
